// *** ramdac_host_model.sv ***
// Purpose: Host microprocessor model driving the RAM-DAC MPU port.
// Assumes: The bench makes one access at a time through the access task.
// Notes:   Idle data lines carry the inverse of the last value, so stale data never passes.
`timescale 1ns/1ps

module ramdac_host_model (
    input  wire logic       clk,
    output logic            strobe_n,
    output logic            port_select_high,
    output logic            port_select_low,
    output logic            read_not_write,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n
);
    initial begin
        strobe_n         = 1'b1;
        port_select_high = 1'b0;
        port_select_low  = 1'b0;
        read_not_write   = 1'b1;
        data_in          = 8'h00;
    end

    // Strobe low and high phases last five clocks each, beyond the three the synchroniser needs.
    // Selects, direction and data stay put past the sampling stage after the strobe rises.
    task automatic access(input logic [1:0] sel, input logic rw, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic oe_n);
        @(posedge clk);
        {port_select_high, port_select_low} <= sel;
        read_not_write <= rw;
        data_in        <= wdata;
        strobe_n       <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rdata = data_out;
        oe_n  = data_oe_n;
        @(posedge clk);
        strobe_n <= 1'b1;
        repeat (5) @(posedge clk);
        data_in <= ~wdata;
    endtask : access
endmodule : ramdac_host_model

// *** ramdac_init_config_port.sv ***
// Purpose: MPU port, mode and command registers, palette loading of a triple RAM-DAC.
// Assumes: The host holds selects, read/write and data stable two clocks past strobe release.
// Notes:   An access takes effect when the synchronised strobe rises.
`timescale 1ns/1ps
`include "ramdac_init_consts.svh"

module ramdac_init_config_port
    import ramdac_init_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       strobe_n,
    input  wire logic       port_select_high,
    input  wire logic       port_select_low,
    input  wire logic       read_not_write,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe_n,
    input  wire logic       vsync,
    output logic            pipeline_reset_pulse,
    output logic            load_sync_pulse,
    output logic            normal_operation,
    output logic            bus_10bit,
    output logic            dac_10bit,
    output logic      [7:0] pixel_input_mask,
    output logic            true_colour,
    output logic            pedestal_75,
    output logic            sync_on_green,
    output logic            mux_2to1,
    output logic            divided_clock_output
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [11:0] pin_s1_reg;
    logic [11:0] pin_s2_reg;
    logic        strobe_s3_reg;
    logic        vsync_s3_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_reg    <= 12'hfff;
            pin_s2_reg    <= 12'hfff;
            strobe_s3_reg <= 1'b1;
            vsync_s3_reg  <= 1'b1;
        end else begin
            pin_s1_reg    <= {vsync, strobe_n, port_select_high, port_select_low,
                              data_in};
            pin_s2_reg    <= pin_s1_reg;
            strobe_s3_reg <= pin_s2_reg[10];
            vsync_s3_reg  <= pin_s2_reg[11];
        end
    end
    logic rw_s1_reg;
    logic rw_s2_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rw_s1_reg <= 1'b1;
            rw_s2_reg <= 1'b1;
        end else begin
            rw_s1_reg <= read_not_write;
            rw_s2_reg <= rw_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] address_reg;
    logic [7:0] command_one_reg;
    logic [7:0] command_two_reg;
    logic [7:0] command_three_reg;
    logic [7:0] mask_reg;
    colour_e    colour_reg;

    wire [1:0] sel        = pin_s2_reg[9:8];
    wire [7:0] wdata      = pin_s2_reg[7:0];
    wire       access_end = pin_s2_reg[10] & ~strobe_s3_reg;
    wire       reading    = ~pin_s2_reg[10] & rw_s2_reg;
    wire       wr_end     = access_end & ~rw_s2_reg;
    wire       rd_end     = access_end & rw_s2_reg;
    wire       wr_address = wr_end & (sel == `SEL_ADDRESS);
    wire       wr_control = wr_end & (sel == `SEL_CONTROL);
    wire       wr_mode    = wr_end & (sel == `SEL_MODE);
    wire       pal_end    = access_end & (sel == `SEL_PALETTE);
    wire       hit_mask   = address_reg == `ADDR_PIXEL_MASK;
    wire       hit_cmd1   = address_reg == `ADDR_COMMAND1;
    wire       hit_cmd2   = address_reg == `ADDR_COMMAND2;
    wire       hit_cmd3   = address_reg == `ADDR_COMMAND3;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg          <= `MODE_RESET;
            mask_reg          <= `MASK_RESET;
            command_one_reg   <= `COMMAND_RESET;
            command_two_reg   <= `COMMAND_RESET;
            command_three_reg <= `COMMAND_RESET;
        end else begin
            if (wr_mode) mode_reg <= wdata;
            if (wr_control && hit_mask) mask_reg <= wdata;
            if (wr_control && hit_cmd1) command_one_reg <= wdata;
            if (wr_control && hit_cmd2) command_two_reg <= wdata;
            if (wr_control && hit_cmd3) command_three_reg <= wdata;
        end
    end

    // ------------------------------------------------------------
    // Palette
    // ------------------------------------------------------------
    // Storage is 8 bits per colour; the 10-bit bus mode is not carried here.
    logic [7:0] palette_red   [256];
    logic [7:0] palette_green [256];
    logic [7:0] palette_blue  [256];
    always_ff @(posedge clk) begin
        if (pal_end && !rw_s2_reg && colour_reg == COL_RED) palette_red[address_reg] <= wdata;
        if (pal_end && !rw_s2_reg && colour_reg == COL_GREEN) palette_green[address_reg] <= wdata;
        if (pal_end && !rw_s2_reg && colour_reg == COL_BLUE) palette_blue[address_reg] <= wdata;
    end

    colour_e colour_next;
    always_comb begin
        unique case (colour_reg)
            COL_RED:   colour_next = COL_GREEN;
            COL_GREEN: colour_next = COL_BLUE;
            COL_BLUE:  colour_next = COL_RED;
            default:   colour_next = COL_RED;
        endcase
    end

    // Writing the address restarts the colour walk at red.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            address_reg <= `ADDRESS_RESET;
            colour_reg  <= COL_RED;
        end else if (wr_address) begin
            address_reg <= wdata;
            colour_reg  <= COL_RED;
        end else if (pal_end) begin
            colour_reg <= colour_next;
            if (colour_reg == COL_BLUE) address_reg <= address_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [7:0] ctrl_rd = hit_mask ? mask_reg :
                         hit_cmd1 ? command_one_reg :
                         hit_cmd2 ? command_two_reg :
                         hit_cmd3 ? command_three_reg : `READ_UNMAPPED;
    wire [7:0] pal_rd  = (colour_reg == COL_RED)   ? palette_red[address_reg] :
                         (colour_reg == COL_GREEN) ? palette_green[address_reg] :
                                                     palette_blue[address_reg];
    wire [7:0] rd_mux  = (sel == `SEL_ADDRESS) ? address_reg :
                         (sel == `SEL_CONTROL) ? ctrl_rd :
                         (sel == `SEL_MODE)    ? mode_reg : pal_rd;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out  <= 8'h00;
            data_oe_n <= 1'b1;
        end else begin
            data_out  <= reading ? rd_mux : 8'h00;
            data_oe_n <= ~reading;
        end
    end

    // ------------------------------------------------------------
    // Mode sequences
    // ------------------------------------------------------------
    seq_e pipe_reg;
    seq_e cal_reg;
    wire  pipe_bit  = wdata[`MODE_PIPE_BIT];
    wire  cal_bit   = wdata[`MODE_CAL_BIT];
    wire  pipe_fire = wr_mode & pipe_bit & (pipe_reg == SEQ_SECOND);
    wire  cal_fire  = wr_mode & ~cal_bit & (cal_reg == SEQ_SECOND);
    wire  vsync_cal = pin_s2_reg[11] & ~vsync_s3_reg & command_one_reg[`CMD1_VCAL_BIT];
    seq_e pipe_next;
    seq_e cal_next;
    // Only the first value may lead to the middle one; a repeated middle value drops the
    // sequence, so a stray 1-0-0-1 never resets the pipelines.
    assign pipe_next = pipe_bit ? SEQ_FIRST : ((pipe_reg == SEQ_FIRST) ? SEQ_SECOND : SEQ_IDLE);
    assign cal_next  = ~cal_bit ? SEQ_FIRST : ((cal_reg == SEQ_FIRST) ? SEQ_SECOND : SEQ_IDLE);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pipe_reg             <= SEQ_IDLE;
            cal_reg              <= SEQ_IDLE;
            pipeline_reset_pulse <= 1'b0;
            load_sync_pulse      <= 1'b0;
        end else begin
            if (wr_mode) pipe_reg <= pipe_next;
            if (wr_mode) cal_reg <= cal_next;
            pipeline_reset_pulse <= pipe_fire;
            load_sync_pulse      <= cal_fire | vsync_cal;
        end
    end

    // ------------------------------------------------------------
    // Decoded settings and clock divider
    // ------------------------------------------------------------
    logic [`DIV_WIDTH-1:0] div_reg;
    wire  div_tap = command_three_reg[`CMD3_DIV8_BIT] ? div_reg[`DIV8_TAP] : div_reg[`DIV4_TAP];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg              <= '0;
            divided_clock_output <= 1'b0;
            normal_operation     <= 1'b0;
            bus_10bit            <= 1'b0;
            dac_10bit            <= 1'b0;
            pixel_input_mask     <= `MASK_RESET;
            true_colour          <= 1'b0;
            pedestal_75          <= 1'b0;
            sync_on_green        <= 1'b0;
            mux_2to1             <= 1'b0;
        end else begin
            div_reg              <= div_reg + `DIV_WIDTH'(1);
            divided_clock_output <= div_tap;
            normal_operation     <= mode_reg[`MODE_NORMAL_BIT];
            bus_10bit            <= mode_reg[`MODE_BUS10_BIT];
            dac_10bit            <= mode_reg[`MODE_DAC10_BIT];
            pixel_input_mask     <= mask_reg;
            true_colour          <= command_two_reg[`CMD2_COLOUR_MSB:`CMD2_COLOUR_LSB]
                                    == `CMD2_TRUE_COL;
            pedestal_75          <= command_two_reg[`CMD2_PED_BIT];
            sync_on_green        <= command_two_reg[`CMD2_SOG_BIT];
            mux_2to1             <= command_three_reg[`CMD3_MUX_BIT];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_pipe_reset_cause: assert property (pipeline_reset_pulse |-> $past(pipe_fire))
        else $error("pipeline reset without a 1-0-1 sequence");
    a_pipe_reset_fires: assert property (pipe_fire |=> pipeline_reset_pulse)
        else $error("pipeline reset missed");
    a_cal_sync_fires: assert property (cal_fire |=> load_sync_pulse)
        else $error("load timing sync missed");
    a_mode_normal_map: assert property (mode_reg == 8'h09 |=>
        normal_operation && !bus_10bit && !dac_10bit)
        else $error("mode 09H not decoded as normal 8-bit");
    a_mask_write_lands: assert property (wr_control && address_reg == 8'h04 |=>
        mask_reg == $past(wdata))
        else $error("pixel mask write lost");
    a_mask_all_ones: assert property (mask_reg == 8'hff |=> pixel_input_mask == 8'hff)
        else $error("pixel mask not all ones");
    a_cmd2_true_colour: assert property (command_two_reg == 8'hec |=>
        true_colour && pedestal_75 && sync_on_green)
        else $error("command two ECH decode wrong");
    a_div_output_rate: assert property ($rose(divided_clock_output) &&
        command_three_reg == 8'h40 && $stable(command_three_reg) |=>
        divided_clock_output[*1] ##1 !divided_clock_output)
        else $error("divided clock not pixel clock /4");
    a_vsync_cal_off: assert property (command_one_reg == 8'h00 && !cal_fire |=>
        !load_sync_pulse)
        else $error("calibration fired with vsync option off");
    a_blue_advance: assert property (pal_end && colour_reg == COL_BLUE && !wr_address |=>
        address_reg == $past(address_reg) + 8'h01 && colour_reg == COL_RED)
        else $error("palette address did not advance after blue");
    a_address_restart: assert property (wr_address |=>
        address_reg == $past(wdata) && colour_reg == COL_RED)
        else $error("address write did not restart at red");

    c_pipe_reset: cover property (pipeline_reset_pulse);
    c_cal_sync: cover property (load_sync_pulse);
    c_palette_wrap: cover property (pal_end && colour_reg == COL_BLUE && address_reg == 8'hff);
    c_control_read: cover property (rd_end && sel == `SEL_CONTROL && hit_cmd2);

endmodule : ramdac_init_config_port

// *** ramdac_init_consts.svh ***
// Purpose: Offsets, field positions and reset values of the RAM-DAC MPU port.
// Assumes: 8-bit MPU data bus; selects coded as {port_select_high, port_select_low}.
// Notes:   Definitions only.
`ifndef RAMDAC_INIT_CONSTS_SVH
`define RAMDAC_INIT_CONSTS_SVH

`define SEL_ADDRESS     2'b00
`define SEL_CONTROL     2'b10
`define SEL_PALETTE     2'b01
`define SEL_MODE        2'b11

`define ADDR_PIXEL_MASK 8'h04
`define ADDR_COMMAND1   8'h05
`define ADDR_COMMAND2   8'h06
`define ADDR_COMMAND3   8'h07

`define MODE_RESET      8'h00
`define MASK_RESET      8'hff
`define COMMAND_RESET   8'h00
`define ADDRESS_RESET   8'h00
`define READ_UNMAPPED   8'h00

`define MODE_PIPE_BIT   0
`define MODE_BUS10_BIT  1
`define MODE_DAC10_BIT  2
`define MODE_NORMAL_BIT 3
`define MODE_CAL_BIT    5

`define CMD1_VCAL_BIT   0
`define CMD2_COLOUR_MSB 7
`define CMD2_COLOUR_LSB 5
`define CMD2_TRUE_COL   3'h7
`define CMD2_PED_BIT    3
`define CMD2_SOG_BIT    2
`define CMD3_MUX_BIT    6
`define CMD3_DIV8_BIT   0

`define DIV_WIDTH       3
`define DIV4_TAP        1
`define DIV8_TAP        2

`endif

// *** ramdac_init_pkg.sv ***
// Purpose: Types shared by the RAM-DAC MPU port logic.
// Assumes: Nothing beyond the constants header.
// Notes:   States carry no explicit codes.
package ramdac_init_pkg;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND} seq_e;
    typedef enum logic [1:0] {COL_RED, COL_GREEN, COL_BLUE} colour_e;
endpackage : ramdac_init_pkg

// *** tb_ramdac_init_config_port.sv ***
// Purpose: Self-checking bench for the RAM-DAC MPU port and its initialisation sequences.
// Assumes: One 20 MHz clock; the host model paces every access.
// Notes:   Pulses are counted on every clock so a one-cycle pulse is never missed.
`timescale 1ns/1ps
`include "ramdac_init_consts.svh"

module tb_ramdac_init_config_port;
    logic       clk, arst_n, vsync, strobe_n, sel_hi, sel_lo, rnw, data_oe_n, oe;
    logic       pipe_p, load_p, norm, b10, d10, tcol, ped, sog, mux, divclk;
    logic [7:0] data_in, data_out, mask, rd, v, loc, n;
    logic [7:0] pal [0:767];
    logic [7:0] mode_seq [0:4] = '{8'h09, 8'h08, 8'h09, 8'h29, 8'h09};
    integer     errors = 0, n_compared = 0, seed = 32'hd68bdc3b, pipe_cnt = 0, load_cnt = 0;

    ramdac_host_model host (.clk(clk), .strobe_n(strobe_n), .port_select_high(sel_hi),
        .port_select_low(sel_lo), .read_not_write(rnw), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n));

    ramdac_init_config_port dut (.clk(clk), .arst_n(arst_n), .strobe_n(strobe_n),
        .port_select_high(sel_hi), .port_select_low(sel_lo), .read_not_write(rnw),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .vsync(vsync),
        .pipeline_reset_pulse(pipe_p), .load_sync_pulse(load_p), .normal_operation(norm),
        .bus_10bit(b10), .dac_10bit(d10), .pixel_input_mask(mask), .true_colour(tcol),
        .pedestal_75(ped), .sync_on_green(sog), .mux_2to1(mux), .divided_clock_output(divclk));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (pipe_p === 1'b1) pipe_cnt++;
        if (load_p === 1'b1) load_cnt++;
    end

    // ----------------------------------------
    // Expectation helpers
    // ----------------------------------------
    function automatic logic [7:0] cmd2_view(input logic [7:0] c);
        return {5'h00, c[7:5] == 3'h7, c[3], c[2]};
    endfunction : cmd2_view

    function automatic logic [7:0] div_period(input logic [7:0] c);
        return c[0] ? 8'h08 : 8'h04;
    endfunction : div_period

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        n_compared++;
        if (seen !== expected) begin
            errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask : check

    task automatic give_verdict;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic acc(input logic [1:0] sel, input logic rw, input logic [7:0] d);
        host.access(sel, rw, d, rd, oe);
        #1;
    endtask : acc

    task automatic setreg(input logic [7:0] a, input logic [7:0] d);
        acc(`SEL_ADDRESS, 1'b0, a);
        acc(`SEL_CONTROL, 1'b0, d);
    endtask : setreg

    task automatic pulse_vsync;
        @(posedge clk);
        vsync <= 1'b1;
        repeat (6) @(posedge clk);
        vsync <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask : pulse_vsync

    // Counts clocks between two rises of the divided clock output.
    task automatic period(output logic [7:0] p);
        integer k, first;
        logic   prev;
        first = -1;
        p     = 8'h00;
        prev  = divclk;
        for (k = 0; k < 24; k++) begin
            @(posedge clk);
            #1;
            if (divclk === 1'b1 && prev === 1'b0) begin
                if (first >= 0 && p == 8'h00) p = 8'(k - first);
                if (first < 0) first = k;
            end
            prev = divclk;
        end
    endtask : period

    initial begin
        #(50 * 30000);
        errors++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        vsync  = 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(mask, 8'hff);
        check({7'h00, data_oe_n}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            acc(`SEL_MODE, 1'b0, mode_seq[i]);
            check(8'(pipe_cnt), (i >= 2) ? 8'h01 : 8'h00);
            check(8'(load_cnt), (i == 4) ? 8'h01 : 8'h00);
        end
        check({5'h00, norm, d10, b10}, 8'h04);
        acc(`SEL_MODE, 1'b1, 8'h00);
        check(rd, 8'h09);
        check({7'h00, oe}, 8'h00);
        acc(`SEL_MODE, 1'b0, 8'h0f);
        check({5'h00, norm, d10, b10}, 8'h07);
        for (int i = 0; i < 3; i++) begin
            acc(`SEL_MODE, 1'b0, (i == 2) ? 8'h09 : 8'h08);
        end
        check(8'(pipe_cnt), 8'h01);
        check(8'(load_cnt), 8'h01);
        check({5'h00, norm, d10, b10}, 8'h04);
        for (int a = 4; a < 8; a++) begin
            v = 8'($random(seed));
            setreg(8'(a), v);
            if (a == 4) check(mask, v);
            acc(`SEL_CONTROL, 1'b1, 8'h00);
            check(rd, v);
        end
        setreg(`ADDR_PIXEL_MASK, 8'hff);
        check(mask, 8'hff);
        setreg(8'h08, 8'h5a);
        acc(`SEL_CONTROL, 1'b1, 8'h00);
        check(rd, 8'h00);
        setreg(`ADDR_COMMAND1, 8'h00);
        pulse_vsync();
        check(8'(load_cnt), 8'h01);
        setreg(`ADDR_COMMAND1, 8'h01);
        pulse_vsync();
        check(8'(load_cnt), 8'h02);
        setreg(`ADDR_COMMAND2, 8'hec);
        check({5'h00, tcol, ped, sog}, cmd2_view(8'hec));
        foreach (mode_seq[i]) begin
            if (i < 2) begin
                v = 8'h40 | 8'(i);
                setreg(`ADDR_COMMAND3, v);
                period(n);
                check(n, div_period(v));
                check({7'h00, mux}, 8'h01);
            end
        end
        acc(`SEL_ADDRESS, 1'b0, 8'h00);
        for (int i = 0; i < 768; i++) begin
            pal[i] = 8'($random(seed));
            acc(`SEL_PALETTE, 1'b0, pal[i]);
        end
        for (int t = 0; t < 4; t++) begin
            loc = (t == 0) ? 8'hff : 8'($random(seed));
            acc(`SEL_ADDRESS, 1'b0, loc);
            for (int c = 0; c < 3; c++) begin
                acc(`SEL_PALETTE, 1'b1, 8'h00);
                check(rd, pal[3 * loc + c]);
            end
            acc(`SEL_ADDRESS, 1'b1, 8'h00);
            check(rd, loc + 8'h01);
        end
        give_verdict();
    end
endmodule : tb_ramdac_init_config_port
